// >>> core/addr_buf_pkg.sv
// Shared constants and types for the address buffer and power control block
// Overview of operation
// RULE_01 - Speed switch feeds mux position 0
// RULE_02 - CPU power good feeds mux position 1
// RULE_03 - Keyboard local request feeds mux position 2
// RULE_04 - Spare inputs feed positions 4, 6, 7
// RULE_05 - Select lines choose the mux output
// RULE_06 - Select n picks n; 3, 5 low
// RULE_07 - After power-up, strap pin outputs watchdog strobe
// RULE_08 - During power-up, strap pin selects switch type
// RULE_09 - Board straps low momentary, high lid
// RULE_10 - Base pin later drives register chip select
// RULE_11 - Base pin sampled at reset: 3.3V
// RULE_12 - Port pin later drives port Z select
// RULE_13 - Port pin sampled at reset: 5V
// RULE_14 - Board never straps both supply pins low
// RULE_15 - Straps captured at release, held, then outputs
// RULE_16 - Control register bits appear on pins
// RULE_17 - No pin for oscillator bit 0
// RULE_18 - Panel enable follows control bit 1
// RULE_19 - Drive reset gated by bit 12
// RULE_20 - Drive reset released while bit 12 set
// RULE_21 - Low strobe loads 0:7, high loads 8:15
// RULE_22 - Loaded byte comes from RAM address bus
// RULE_23 - CPU address pins are inputs while master
// RULE_24 - Latched address drives early and system lines
// RULE_25 - Master high drives SBHE and SA1-16
// RULE_26 - SA17-19 always driven onto the bus
package addr_buf_pkg;

  // Control register layout
  localparam int          PCR_WIDTH      = 16;
  localparam int          PCR_BYTE       = 8;
  localparam int          PCR_OSCILLATOR_BIT = 0;
  localparam int          PCR_PANEL_BIT  = 1;
  localparam int          PCR_DRIVE_BIT  = 12;
  localparam logic [15:0] PCR_RESET_VAL  = 16'h0000;

  // Mux positions
  localparam int          MUX_INPUTS     = 8;
  localparam int          MUX_SEL_WIDTH  = 3;
  localparam int          MUX_POS_SPEED  = 0;
  localparam int          MUX_POS_PGOOD  = 1;
  localparam int          MUX_POS_LOCAL  = 2;
  localparam int          MUX_POS_NONE_A = 3;
  localparam int          MUX_POS_SPARE_A = 4;
  localparam int          MUX_POS_NONE_B = 5;
  localparam int          MUX_POS_SPARE_B = 6;
  localparam int          MUX_POS_SPARE_C = 7;

  // Watchdog strobe timing
  localparam int          CLK_FREQ_HZ    = 10_000_000;
  localparam int          WD_PERIOD_MS   = 120;
  localparam int          WD_CYCLES      = WD_PERIOD_MS * (CLK_FREQ_HZ / 1000);

  // Address bus widths
  localparam int          ADDR_MSB       = 23;
  localparam int          SA_LO_MSB      = 16;

  // Strap phase of the shared pins
  typedef enum logic [1:0] {
    PH_RESET = 2'b00,
    PH_RUN   = 2'b01
  } phase_e;

  // Straps captured as reset goes away
  typedef struct packed {
    logic lid_switch;
    logic base_strap;
    logic port_strap;
  } strap_s;

  // CPU address as held by the ALE latch; bit 20 is carried but unused
  typedef struct packed {
    logic        bhe;
    logic [23:1] a;
  } addr_s;

endpackage

// >>> core/pm_input_mux.sv
// Power management input multiplexer with registered output
module pm_input_mux #(
  parameter int N_IN  = addr_buf_pkg::MUX_INPUTS,
  parameter int SEL_W = addr_buf_pkg::MUX_SEL_WIDTH
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [N_IN-1:0]  sources,
  input  wire logic [SEL_W-1:0] select,
  output logic                  mux_out
);

  logic mux_ff;
  logic nxt_mux;

  // Select value n picks position n
  always_comb begin
    nxt_mux = sources[select]; // RULE_05
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mux_ff <= 1'b0;
    end else begin
      mux_ff <= nxt_mux;
    end
  end

  assign mux_out = mux_ff;

endmodule

// >>> core/power_ctrl_reg.sv
// Sixteen-bit power control register loaded a byte per strobe
module power_ctrl_reg #(
  parameter int W = addr_buf_pkg::PCR_WIDTH,
  parameter int B = addr_buf_pkg::PCR_BYTE
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         strobe_lo,
  input  wire logic         strobe_hi,
  input  wire logic [B-1:0] byte_in,
  output logic      [W-1:0] value
);

  logic [W-1:0] pcr_ff;
  logic [W-1:0] nxt_pcr;

  // Each strobe loads its own byte lane; both may fire together
  always_comb begin
    nxt_pcr = pcr_ff;
    if (strobe_lo) begin
      nxt_pcr[B-1:0] = byte_in; // RULE_21 RULE_22
    end
    if (strobe_hi) begin
      nxt_pcr[W-1:B] = byte_in; // RULE_21 RULE_22
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pcr_ff <= addr_buf_pkg::PCR_RESET_VAL;
    end else begin
      pcr_ff <= nxt_pcr;
    end
  end

  assign value = pcr_ff;

endmodule

// >>> core/address_buffer_power_control.sv
// Address buffer, power control register, mux and strap pins
module address_buffer_power_control #(
  parameter int WD_PERIOD_CYCLES = addr_buf_pkg::WD_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Power management mux
  input  wire logic        speed_switch_in,
  input  wire logic        cpu_power_good,
  input  wire logic        local_access_request,
  input  wire logic        pm_spare_in_a,
  input  wire logic        pm_spare_in_b,
  input  wire logic        pm_spare_in_c,
  input  wire logic [2:0]  pm_mux_select,
  output logic             pm_mux_out,
  // Power control register load
  input  wire logic        power_ctrl_write_strobe_lo,
  input  wire logic        power_ctrl_write_strobe_hi,
  input  wire logic [7:0]  ram_addr_bus_in,
  output logic [15:1]      power_ctrl_out,
  output logic             panel_enable,
  output logic             drive_power_on,
  output logic             drive_reset_out,
  output logic             drive_reset_oe_n,
  // Shared strap pins
  input  wire logic        watchdog_strobe_strap_in,
  output logic             watchdog_strobe_strap_out,
  output logic             watchdog_strobe_strap_oe_n,
  input  wire logic        base_reg_select_strap_in,
  output logic             base_reg_select_strap_out,
  output logic             base_reg_select_strap_oe_n,
  input  wire logic        readonly_port_select_strap_in,
  output logic             readonly_port_select_strap_out,
  output logic             readonly_port_select_strap_oe_n,
  input  wire logic        base_regs_cs_req_n,
  input  wire logic        port_z_cs_req_n,
  output logic             lid_switch_mode,
  output logic             all_3v3_mode,
  output logic             all_5v_mode,
  // Address buffer
  input  wire logic        master,
  input  wire logic        ale,
  input  wire logic [23:1] cpu_addr_in,
  input  wire logic        bhe_in,
  output logic [16:1]      sa_lo_out,
  output logic             sa_lo_oe_n,
  output logic             sbhe_out,
  output logic             sbhe_oe_n,
  output logic [19:17]     sa_hi_out,
  output logic [19:17]     la_lo_out,
  output logic [23:21]     la_hi_out,
  output logic             la_oe_n
);

  // ---------------- Power management input mux ----------------
  logic [addr_buf_pkg::MUX_INPUTS-1:0] mux_src;

  // Positions 3 and 5 have no source and read low
  always_comb begin
    mux_src                                = '0; // RULE_06
    mux_src[addr_buf_pkg::MUX_POS_SPEED]   = speed_switch_in; // RULE_01
    mux_src[addr_buf_pkg::MUX_POS_PGOOD]   = cpu_power_good; // RULE_02
    mux_src[addr_buf_pkg::MUX_POS_LOCAL]   = local_access_request; // RULE_03
    mux_src[addr_buf_pkg::MUX_POS_SPARE_A] = pm_spare_in_a; // RULE_04
    mux_src[addr_buf_pkg::MUX_POS_SPARE_B] = pm_spare_in_b; // RULE_04
    mux_src[addr_buf_pkg::MUX_POS_SPARE_C] = pm_spare_in_c; // RULE_04
  end

  pm_input_mux i_pm_input_mux (
    .core_clk (core_clk),
    .rst      (rst),
    .sources  (mux_src),
    .select   (pm_mux_select),
    .mux_out  (pm_mux_out)
  );

  // ---------------- Power control register ----------------
  logic [15:0] pcr;

  power_ctrl_reg i_power_ctrl_reg (
    .core_clk  (core_clk),
    .rst       (rst),
    .strobe_lo (power_ctrl_write_strobe_lo),
    .strobe_hi (power_ctrl_write_strobe_hi),
    .byte_in   (ram_addr_bus_in),
    .value     (pcr)
  );

  // Bit 0 only steers an oscillator direction fixed low, so it has no pin
  assign power_ctrl_out   = pcr[15:1]; // RULE_16 RULE_17
  assign panel_enable     = pcr[addr_buf_pkg::PCR_PANEL_BIT]; // RULE_18
  assign drive_power_on   = pcr[addr_buf_pkg::PCR_DRIVE_BIT];
  // Open drain: pulls low while the drive is unpowered, floats once powered
  assign drive_reset_out  = 1'b0; // RULE_19
  assign drive_reset_oe_n = pcr[addr_buf_pkg::PCR_DRIVE_BIT]; // RULE_20

  // ---------------- Strap capture and pin role ----------------
  addr_buf_pkg::phase_e  phase_ff;
  addr_buf_pkg::phase_e  nxt_phase;
  addr_buf_pkg::strap_s  strap_ff;
  addr_buf_pkg::strap_s  nxt_strap;

  // Pins stay inputs through reset and the first edge after it; that
  // edge takes the straps, so pull-ups have had all of reset to settle
  always_comb begin
    nxt_phase = phase_ff;
    nxt_strap = strap_ff;
    case (phase_ff)
      addr_buf_pkg::PH_RESET: begin
        nxt_strap.lid_switch = watchdog_strobe_strap_in; // RULE_08 RULE_09
        nxt_strap.base_strap = base_reg_select_strap_in; // RULE_11
        nxt_strap.port_strap = readonly_port_select_strap_in; // RULE_13
        nxt_phase            = addr_buf_pkg::PH_RUN; // RULE_15
      end
      addr_buf_pkg::PH_RUN: begin
        nxt_phase = addr_buf_pkg::PH_RUN;
      end
      default: begin
        nxt_phase = addr_buf_pkg::PH_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_ff <= addr_buf_pkg::PH_RESET;
      strap_ff <= '1;
    end else begin
      phase_ff <= nxt_phase;
      strap_ff <= nxt_strap;
    end
  end

  logic run;
  assign run = (phase_ff == addr_buf_pkg::PH_RUN);

  // Decoded supply modes; both straps low is not a legal board setting
  assign lid_switch_mode = strap_ff.lid_switch;
  assign all_3v3_mode    = !strap_ff.base_strap && strap_ff.port_strap; // RULE_14
  assign all_5v_mode     = strap_ff.base_strap && !strap_ff.port_strap; // RULE_14

  // ---------------- Watchdog strobe ----------------
  logic [31:0] wd_cnt_ff;
  logic [31:0] nxt_wd_cnt;
  logic        wd_pulse_ff;
  logic        nxt_wd_pulse;

  // One-cycle strobe each period, counted only once straps are taken
  always_comb begin
    nxt_wd_cnt   = wd_cnt_ff;
    nxt_wd_pulse = 1'b0;
    if (run) begin
      if (wd_cnt_ff == 32'(WD_PERIOD_CYCLES - 1)) begin
        nxt_wd_cnt   = 32'h0000_0000;
        nxt_wd_pulse = 1'b1; // RULE_07
      end else begin
        nxt_wd_cnt = wd_cnt_ff + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wd_cnt_ff   <= 32'h0000_0000;
      wd_pulse_ff <= 1'b0;
    end else begin
      wd_cnt_ff   <= nxt_wd_cnt;
      wd_pulse_ff <= nxt_wd_pulse;
    end
  end

  // Shared pins turn to outputs only after capture
  logic base_cs_ff;
  logic nxt_base_cs;
  logic port_cs_ff;
  logic nxt_port_cs;

  always_comb begin
    nxt_base_cs = base_regs_cs_req_n; // RULE_10
    nxt_port_cs = port_z_cs_req_n; // RULE_12
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      base_cs_ff <= 1'b1;
      port_cs_ff <= 1'b1;
    end else begin
      base_cs_ff <= nxt_base_cs;
      port_cs_ff <= nxt_port_cs;
    end
  end

  assign watchdog_strobe_strap_out       = wd_pulse_ff;
  assign watchdog_strobe_strap_oe_n      = !run; // RULE_07 RULE_15
  assign base_reg_select_strap_out       = base_cs_ff;
  assign base_reg_select_strap_oe_n      = !run; // RULE_10 RULE_15
  assign readonly_port_select_strap_out  = port_cs_ff;
  assign readonly_port_select_strap_oe_n = !run; // RULE_12 RULE_15

  // ---------------- Address latch ----------------
  addr_buf_pkg::addr_s addr_ff;
  addr_buf_pkg::addr_s nxt_addr;

  // CPU pins are only taken as inputs while master is high
  always_comb begin
    nxt_addr = addr_ff;
    if (master && ale) begin
      nxt_addr.a   = cpu_addr_in; // RULE_23
      nxt_addr.bhe = bhe_in; // RULE_23
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      addr_ff <= '0;
    end else begin
      addr_ff <= nxt_addr;
    end
  end

  // Bus drivers; the reverse path with master low is not built here
  assign sa_lo_out  = addr_ff.a[16:1]; // RULE_24 RULE_25
  assign sbhe_out   = addr_ff.bhe; // RULE_25
  assign sa_lo_oe_n = !master; // RULE_25
  assign sbhe_oe_n  = !master; // RULE_25
  assign sa_hi_out  = addr_ff.a[19:17]; // RULE_26
  assign la_lo_out  = addr_ff.a[19:17]; // RULE_24
  assign la_hi_out  = addr_ff.a[23:21]; // RULE_24
  assign la_oe_n    = !master; // RULE_24

  // ---------------- Assertions ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_mux_pos0;
    pm_mux_select == 3'h0 |=> pm_mux_out == $past(speed_switch_in);
  endproperty
  a_mux_pos0: assert property (p_mux_pos0) else $error("mux pos 0 wrong"); // RULE_01

  property p_mux_pos1;
    pm_mux_select == 3'h1 |=> pm_mux_out == $past(cpu_power_good);
  endproperty
  a_mux_pos1: assert property (p_mux_pos1) else $error("mux pos 1 wrong"); // RULE_02

  property p_mux_pos2;
    pm_mux_select == 3'h2 |=> pm_mux_out == $past(local_access_request);
  endproperty
  a_mux_pos2: assert property (p_mux_pos2) else $error("mux pos 2 wrong"); // RULE_03

  property p_mux_pos4;
    pm_mux_select == 3'h4 |=> pm_mux_out == $past(pm_spare_in_a);
  endproperty
  a_mux_pos4: assert property (p_mux_pos4) else $error("mux pos 4 wrong"); // RULE_04

  property p_mux_pos6;
    pm_mux_select == 3'h6 |=> pm_mux_out == $past(pm_spare_in_b);
  endproperty
  a_mux_pos6: assert property (p_mux_pos6) else $error("mux pos 6 wrong"); // RULE_04

  property p_mux_pos7;
    pm_mux_select == 3'h7 |=> pm_mux_out == $past(pm_spare_in_c);
  endproperty
  a_mux_pos7: assert property (p_mux_pos7) else $error("mux pos 7 wrong"); // RULE_04

  property p_mux_empty;
    (pm_mux_select == 3'h3 || pm_mux_select == 3'h5) |=> !pm_mux_out;
  endproperty
  a_mux_empty: assert property (p_mux_empty) else $error("empty pos not low"); // RULE_06

  property p_pcr_lo;
    power_ctrl_write_strobe_lo
      |=> power_ctrl_out[7:1] == $past(ram_addr_bus_in[7:1]);
  endproperty
  a_pcr_lo: assert property (p_pcr_lo) else $error("low byte not loaded"); // RULE_21

  property p_drive_release;
    power_ctrl_write_strobe_hi && ram_addr_bus_in[4] |=> drive_reset_oe_n;
  endproperty
  a_drive_release: assert property (p_drive_release) else $error("drive reset held"); // RULE_20

  property p_strap_held;
    run |=> $stable(strap_ff) && !base_reg_select_strap_oe_n;
  endproperty
  a_strap_held: assert property (p_strap_held) else $error("strap changed"); // RULE_15

  // Once the pins are outputs, each select request shows one cycle later
  property p_cs_follow;
    run |=> base_reg_select_strap_out == $past(base_regs_cs_req_n)
            && readonly_port_select_strap_out == $past(port_z_cs_req_n);
  endproperty
  a_cs_follow: assert property (p_cs_follow) else $error("chip select lost"); // RULE_10 RULE_12

  property p_addr_latch;
    master && ale |=> sa_lo_out == $past(cpu_addr_in[16:1])
                      && la_hi_out == $past(cpu_addr_in[23:21]);
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("address not latched"); // RULE_24

  property p_wd_spacing;
    watchdog_strobe_strap_out |=> !watchdog_strobe_strap_out [*8];
  endproperty
  a_wd_spacing: assert property (p_wd_spacing) else $error("strobe too close"); // RULE_07

  c_strap_taken: cover property (phase_ff == addr_buf_pkg::PH_RESET ##1 run);
  c_wd_pulse:    cover property (watchdog_strobe_strap_out);
  c_pcr_write:   cover property (power_ctrl_write_strobe_hi ##1 drive_reset_oe_n);
  c_addr_load:   cover property (master && ale ##1 !sa_lo_oe_n);

endmodule

// >>> verification/strap_board_model.sv
// Board side of the shared strap pins: resistor straps and wire resolution
module strap_board_model (
  input  wire logic                 wd_out,
  input  wire logic                 wd_oe_n,
  input  wire logic                 base_out,
  input  wire logic                 base_oe_n,
  input  wire logic                 port_out,
  input  wire logic                 port_oe_n,
  input  wire addr_buf_pkg::strap_s straps,
  output logic                      wd_in,
  output logic                      base_in,
  output logic                      port_in
);
  timeunit 1ns;
  timeprecision 1ns;

  // Device wins while it drives; otherwise the strap resistor sets the level
  assign wd_in   = !wd_oe_n ? wd_out : straps.lid_switch;
  assign base_in = !base_oe_n ? base_out : straps.base_strap;
  // Illegal both-low pair never reaches the pins, the port strap floats high then
  assign port_in = !port_oe_n ? port_out : (straps.port_strap | !straps.base_strap);
endmodule

// >>> verification/test_address_buffer_power_control.sv
// Self-checking bench for the address buffer and power control block
module test_address_buffer_power_control;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int WD = 20;
  logic core_clk = 1'b0, rst = 1'b1;
  logic speed, pgood, lcl, sp_a, sp_b, sp_c, mux_out, st_lo, st_hi, panel, dpo, drst, drst_oe_n;
  logic [2:0]  sel;
  logic [7:0]  bus;
  logic [15:1] pcr;
  logic wd_in, wd_out, wd_oe_n, b_in, b_out, b_oe_n, p_in, p_out, p_oe_n, b_req_n, p_req_n;
  logic lid, v33, v5, master, ale, bhe, sbhe, sbhe_oe_n, sa_oe_n, la_oe_n;
  logic [23:1] addr;
  logic [16:1] sa_lo;
  logic [19:17] sa_hi, la_lo;
  logic [23:21] la_hi;
  addr_buf_pkg::strap_s straps;
  int bad_count = 0, samples_checked = 0;

  // Free-running core clock, 100 ns period
  always #50 core_clk = ~core_clk;

  address_buffer_power_control #(.WD_PERIOD_CYCLES(WD)) i_address_buffer_power_control (
    .core_clk(core_clk), .rst(rst), .speed_switch_in(speed), .cpu_power_good(pgood),
    .local_access_request(lcl), .pm_spare_in_a(sp_a), .pm_spare_in_b(sp_b),
    .pm_spare_in_c(sp_c), .pm_mux_select(sel), .pm_mux_out(mux_out),
    .power_ctrl_write_strobe_lo(st_lo), .power_ctrl_write_strobe_hi(st_hi),
    .ram_addr_bus_in(bus), .power_ctrl_out(pcr), .panel_enable(panel), .drive_power_on(dpo),
    .drive_reset_out(drst), .drive_reset_oe_n(drst_oe_n),
    .watchdog_strobe_strap_in(wd_in), .watchdog_strobe_strap_out(wd_out),
    .watchdog_strobe_strap_oe_n(wd_oe_n), .base_reg_select_strap_in(b_in),
    .base_reg_select_strap_out(b_out), .base_reg_select_strap_oe_n(b_oe_n),
    .readonly_port_select_strap_in(p_in), .readonly_port_select_strap_out(p_out),
    .readonly_port_select_strap_oe_n(p_oe_n), .base_regs_cs_req_n(b_req_n),
    .port_z_cs_req_n(p_req_n), .lid_switch_mode(lid), .all_3v3_mode(v33), .all_5v_mode(v5),
    .master(master), .ale(ale), .cpu_addr_in(addr), .bhe_in(bhe), .sa_lo_out(sa_lo),
    .sa_lo_oe_n(sa_oe_n), .sbhe_out(sbhe), .sbhe_oe_n(sbhe_oe_n), .sa_hi_out(sa_hi),
    .la_lo_out(la_lo), .la_hi_out(la_hi), .la_oe_n(la_oe_n));

  strap_board_model i_strap_board_model (
    .wd_out(wd_out), .wd_oe_n(wd_oe_n), .base_out(b_out), .base_oe_n(b_oe_n),
    .port_out(p_out), .port_oe_n(p_oe_n), .straps(straps), .wd_in(wd_in), .base_in(b_in),
    .port_in(p_in));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Inputs always change 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic complete_run;
    $display("checks=%0d bad=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Reset with each legal base/port strap pair; the modes must follow the capture and hold
  task automatic test_straps;
    logic [2:0] sets [3];
    sets = '{3'b101, 3'b010, 3'b111};
    for (int i = 0; i < 3; i++) begin
      straps = addr_buf_pkg::strap_s'(sets[i]);
      rst = 1'b1;
      step(4);
      check({wd_oe_n, b_oe_n, p_oe_n}, 3'h7);
      check({b_out, p_out, drst_oe_n}, 3'h6);
      rst = 1'b0;
      step(2);
      check({wd_oe_n, b_oe_n, p_oe_n}, 3'h0);
      check(lid, straps.lid_switch);
      check(v33, !straps.base_strap && straps.port_strap);
      check(v5, straps.base_strap && !straps.port_strap);
      step(3);
      check({lid, v33, v5}, {straps.lid_switch, !sets[i][1] & sets[i][0],
                             sets[i][1] & !sets[i][0]});
    end
  endtask

  // Every select value, with the chosen source both high and low among opposite levels
  task automatic test_mux;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 2; k++) begin
        v = k ? ~(8'h01 << i) : (8'h01 << i);
        sel = i[2:0];
        {sp_c, sp_b, sp_a, lcl, pgood, speed} = {v[7], v[6], v[4], v[2], v[1], v[0]};
        step(1);
        check(mux_out, (i == 3 || i == 5) ? 1'b0 : v[i]);
      end
    end
  endtask

  // Back-to-back byte loads, then a hold with the strobes low and a drive power-off
  task automatic test_pcr;
    st_lo = 1'b1;
    bus = 8'h03;
    step(1);
    st_lo = 1'b0;
    st_hi = 1'b1;
    bus = 8'h10;
    step(1);
    st_hi = 1'b0;
    bus = 8'hFF;
    check(pcr, {8'h10, 7'h01});
    check({panel, dpo, drst_oe_n, drst}, 4'hE);
    step(1);
    check(pcr, {8'h10, 7'h01});
    st_hi = 1'b1;
    bus = 8'hEF;
    step(1);
    st_hi = 1'b0;
    check(pcr, {8'hEF, 7'h01});
    check({dpo, drst_oe_n, panel}, 3'h1);
  endtask

  // Two captures back to back, then an enable while the bus is not owned
  task automatic test_addr;
    logic [23:1] a;
    a = 23'h5A3C96;
    {master, ale, bhe, addr} = {3'b111, a};
    step(1);
    addr = ~a;
    bhe = 1'b0;
    check({sa_hi, sa_lo, sbhe}, {a[19:1], 1'b1});
    step(1);
    // Enables follow master with no flop, so look before master drops
    check({la_hi, la_lo}, {~a[23:21], ~a[19:17]});
    check({sa_oe_n, sbhe_oe_n, la_oe_n}, 3'h0);
    master = 1'b0;
    addr = a;
    step(1);
    ale = 1'b0;
    check({sa_hi, sa_lo, sbhe}, {~a[19:1], 1'b0});
    check({sa_oe_n, sbhe_oe_n, la_oe_n}, 3'h7);
  endtask

  // Chip select requests reach the shared pins one cycle later
  task automatic test_cs;
    {b_req_n, p_req_n} = 2'b01;
    step(1);
    check({b_out, p_out}, 2'h1);
    {b_req_n, p_req_n} = 2'b10;
    step(1);
    check({b_out, p_out}, 2'h2);
    {b_req_n, p_req_n} = 2'b11;
  endtask

  // Spacing between two strobe pulses equals the watchdog period
  task automatic test_watchdog;
    int n;
    n = 0;
    while (wd_out !== 1'b1 && n < 2 * WD) begin
      step(1);
      n++;
    end
    check(wd_out, 1'b1);
    n = 0;
    step(1);
    while (wd_out !== 1'b1 && n < 2 * WD) begin
      step(1);
      n++;
    end
    check(24'(n + 1), 24'(WD));
  endtask

  // Main sequence
  initial begin
    {speed, pgood, lcl, sp_a, sp_b, sp_c, sel, st_lo, st_hi, bus} = '0;
    {b_req_n, p_req_n, master, ale, bhe, addr} = {2'b11, 26'h0};
    straps = addr_buf_pkg::strap_s'(3'b111);
    test_straps();
    test_mux();
    test_pcr();
    test_addr();
    test_cs();
    test_watchdog();
    complete_run();
  end

  // Watchdog against a hang, far beyond the fewer than a hundred cycles the tests need
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
endmodule
